/* eba_arb_properties.sv */
// Concurrent checks on the processor arbiter interface
module eba_arb_properties (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  // Interface signals
  input wire logic [2:0] processor_id,
  input wire logic       rotating_priority_select,
  input wire logic       host_select_n,
  input wire logic       host_bus_request_n,
  input wire logic       host_ack_ready,
  input wire logic       host_ack_ready_oe,
  input wire logic       host_bus_grant_n,
  input wire logic       dma_request_one_n,
  input wire logic       dma_grant_one_n,
  input wire logic       dma_grant_two_n,
  input wire logic       dma_grant_oe,
  input wire logic [5:0] mp_bus_request_lines_n,
  input wire logic [5:0] mp_bus_request_oe,
  input wire logic       bus_master_indicator
);
  logic [5:0] own_w;
  assign own_w = (processor_id == 3'h0) ? 6'h00 :
                 6'h01 << (processor_id - 3'h1);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_wait_cause: assert property (host_ack_ready_oe |-> !host_ack_ready
    && $past(!host_select_n && !host_bus_request_n)) else $error("bad wait");
  chk_grant_owner: assert property (!(dma_grant_one_n && dma_grant_two_n)
    |-> dma_grant_oe && bus_master_indicator) else $error("grant by slave");
  chk_grant_cause: assert property (!dma_grant_one_n
    |-> $past(!dma_request_one_n)) else $error("grant without request");
  chk_own_line: assert property ((mp_bus_request_oe & ~own_w) == 6'h00)
    else $error("foreign request line driven");
  chk_id_decode: assert property ($rose(bus_master_indicator)
    && $past(host_bus_grant_n)
    && processor_id != 3'h0 |-> $past(mp_bus_request_oe) == own_w)
    else $error("won without own request");
  chk_single_master: assert property (processor_id == 3'h0
    |-> bus_master_indicator) else $error("single not master");
  chk_host_hold: assert property (!host_bus_grant_n && !host_bus_request_n
    |=> !host_bus_grant_n) else $error("host grant dropped");
  chk_host_cause: assert property ($fell(host_bus_grant_n)
    |-> $past(!host_bus_request_n)) else $error("host grant unasked");
  chk_fixed_lowest: assert property (!rotating_priority_select
    && $rose(bus_master_indicator) && processor_id != 3'h0
    && $past(host_bus_grant_n)
    |-> ($past(mp_bus_request_lines_n) | ~(own_w - 6'h01)) == 6'h3F)
    else $error("lower id passed over");
endmodule

/* eba_bus_if.sv */
// Interface joining a processor's arbiter to its system-side partner
interface eba_bus_if;
  import eba_pkg::*;
  logic [2:0] processor_id;
  logic       rotating_priority_select;
  logic       host_select_n;
  logic       host_bus_request_n;
  logic       host_ack_ready;
  logic       host_ack_ready_oe;
  logic       host_bus_grant_n;
  logic       dma_request_one_n;
  logic       dma_request_two_n;
  logic       dma_grant_one_n;
  logic       dma_grant_two_n;
  logic       dma_grant_oe;
  logic [5:0] mp_bus_request_lines_n;
  logic [5:0] mp_bus_request_oe;
  logic       bus_master_indicator;

  modport device (
    input  processor_id, rotating_priority_select, host_select_n,
    input  host_bus_request_n, dma_request_one_n, dma_request_two_n,
    input  mp_bus_request_lines_n,
    output host_ack_ready, host_ack_ready_oe, host_bus_grant_n,
    output dma_grant_one_n, dma_grant_two_n, dma_grant_oe,
    output mp_bus_request_oe, bus_master_indicator
  );
  modport system (
    output processor_id, rotating_priority_select, host_select_n,
    output host_bus_request_n, dma_request_one_n, dma_request_two_n,
    output mp_bus_request_lines_n,
    input  host_ack_ready, host_ack_ready_oe, host_bus_grant_n,
    input  dma_grant_one_n, dma_grant_two_n, dma_grant_oe,
    input  mp_bus_request_oe, bus_master_indicator
  );
endinterface

/* eba_device_end.sv */
// Processor end: bus request arbitration, host and DMA handshakes
module eba_device_end
  import eba_pkg::*;
#(
  parameter int NUM_PROC = EBA_NUM_PROC
)
(
  // Clock and control
  input  wire logic          clk_in,
  input  wire logic          reset_n_in,
  input  wire logic          clk_en_in,
  // Core side
  input  wire logic          want_bus_in,
  input  wire logic          io_processor_busy_in,
  input  wire logic          dma_one_ready_in,
  input  wire logic          dma_two_ready_in,
  output logic               dma_one_start_out,
  output logic               dma_two_start_out,
  output eba_pkg::eba_state_t state_out,
  eba_bus_if.device          bus
);
  import eba_pkg::*;

  // Request line decode is built for exactly six processors
  if (NUM_PROC != EBA_NUM_PROC) begin : g_bad_num_proc
    $error("NUM_PROC must be six");
  end

  // Processor ID to one-hot request line
  function automatic logic [5:0] id_to_line(input logic [2:0] id);
    logic [5:0] r;
    r = 6'h00;
    if (id >= EBA_ID_FIRST && id <= 3'h6) begin
      r[id - EBA_ID_FIRST] = 1'b1;
    end
    return r;
  endfunction

  eba_state_t st_reg, st_next;
  logic [2:0] last_reg, last_next;
  logic       req_reg, req_next;
  logic       g1_reg, g1_next, g2_reg, g2_next;
  logic       s1_reg, s1_next, s2_reg, s2_next;
  logic       ready_reg, ready_next;
  logic       hbg_reg, hbg_next;
  logic       id_single;
  logic [5:0] own_line, other_req, all_req;
  logic [2:0] winner;
  logic       any_req;

  assign id_single = (bus.processor_id == EBA_ID_SINGLE);
  assign own_line  = id_to_line(bus.processor_id);
  assign other_req = ~bus.mp_bus_request_lines_n & ~own_line;
  assign all_req   = other_req | (own_line & {6{req_reg}});

  // Pick winner by fixed or rotating priority
  always_comb begin
    logic [2:0] idx;
    logic       found;
    idx    = 3'h0;
    found  = 1'b0;
    winner = 3'h0;
    for (int k = 0; k < EBA_NUM_PROC; k++) begin
      if (bus.rotating_priority_select) begin
        idx = 3'((int'(last_reg) + k) % EBA_NUM_PROC);
      end else begin
        idx = 3'(k);
      end
      if (!found && all_req[idx]) begin
        found  = 1'b1;
        winner = idx + EBA_ID_FIRST;
      end
    end
    any_req = |all_req;
  end

  always_comb begin
    st_next    = st_reg;
    last_next  = last_reg;
    req_next   = want_bus_in & ~id_single;
    g1_next    = 1'b0;
    g2_next    = 1'b0;
    s1_next    = g1_reg;
    s2_next    = g2_reg;
    hbg_next   = hbg_reg;
    ready_next = ~(~bus.host_select_n & ~bus.host_bus_request_n
                   & io_processor_busy_in);
    case (st_reg)
      EBA_ST_SLAVE: begin
        if (!bus.host_bus_request_n) begin
          st_next = EBA_ST_SLAVE;
        end else if (id_single ||
                     (any_req && winner == bus.processor_id)) begin
          st_next = EBA_ST_MASTER;
        end
      end
      EBA_ST_MASTER: begin
        if (!bus.host_bus_request_n) begin
          st_next  = EBA_ST_HOST;
          hbg_next = 1'b1;
        end else if (!id_single && !req_reg && any_req) begin
          st_next   = EBA_ST_SLAVE;
          last_next = bus.processor_id;
        end else begin
          g1_next = ~bus.dma_request_one_n & dma_one_ready_in;
          g2_next = ~bus.dma_request_two_n & dma_two_ready_in
                    & bus.dma_request_one_n;
        end
      end
      EBA_ST_HOST: begin
        if (bus.host_bus_request_n) begin
          hbg_next = 1'b0;
          st_next  = EBA_ST_MASTER;
        end
      end
      default: st_next = EBA_ST_SLAVE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_reg    <= EBA_ST_SLAVE;
      last_reg  <= EBA_LAST_RESET;
      req_reg   <= 1'b0;
      g1_reg    <= 1'b0;
      g2_reg    <= 1'b0;
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      ready_reg <= 1'b1;
      hbg_reg   <= 1'b0;
    end else if (clk_en_in) begin
      st_reg    <= st_next;
      last_reg  <= last_next;
      req_reg   <= req_next;
      g1_reg    <= g1_next;
      g2_reg    <= g2_next;
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      ready_reg <= ready_next;
      hbg_reg   <= hbg_next;
    end
  end

  // Open-drain ready: only drive low
  assign bus.host_ack_ready    = ready_reg;
  assign bus.host_ack_ready_oe = ~ready_reg;
  assign bus.host_bus_grant_n  = ~hbg_reg;
  assign bus.dma_grant_one_n   = ~g1_reg;
  assign bus.dma_grant_two_n   = ~g2_reg;
  assign bus.dma_grant_oe      = (st_reg == EBA_ST_MASTER);
  assign bus.mp_bus_request_oe = own_line & {6{req_reg}};
  assign bus.bus_master_indicator = id_single ||
                                    (st_reg == EBA_ST_MASTER);
  assign dma_one_start_out = s1_reg;
  assign dma_two_start_out = s2_reg;
  assign state_out         = st_reg;
endmodule

/* eba_pkg.sv */
// Shared constants and types for the external bus arbitration handshake
package eba_pkg;
  localparam int          EBA_NUM_PROC    = 6;
  localparam int          EBA_ID_W        = 3;
  localparam logic [2:0]  EBA_ID_SINGLE   = 3'h0;
  localparam logic [2:0]  EBA_ID_FIRST    = 3'h1;
  localparam logic [5:0]  EBA_BR_IDLE     = 6'h3F;
  localparam logic [2:0]  EBA_LAST_RESET  = 3'h0;

  typedef enum logic [1:0] {
    EBA_ST_SLAVE  = 2'b00,
    EBA_ST_MASTER = 2'b01,
    EBA_ST_HOST   = 2'b10
  } eba_state_t;
endpackage

/* eba_system_end.sv */
// System side: straps, host, DMA devices and peer request lines
module eba_system_end
  import eba_pkg::*;
(
  // Clock and control
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   clk_en_in,
  // Straps
  input  wire logic [2:0]             id_strap_in,
  input  wire logic                   rotate_in,
  // Host, DMA and peer requests
  input  wire logic                   host_select_in,
  input  wire logic                   host_request_in,
  input  wire logic                   dma_one_in,
  input  wire logic                   dma_two_in,
  input  wire logic [5:0]             peer_request_in,
  // Observed answers
  output logic                        host_granted_out,
  output logic                        host_wait_out,
  output logic                        dma_one_granted_out,
  output logic                        dma_two_granted_out,
  output logic                        device_master_out,
  eba_bus_if.system                   bus
);
  import eba_pkg::*;
  logic [2:0] id_reg, id_next;
  logic       rot_reg, rot_next;

  // ID strap only changes under reset; rotate strap follows rotate_in every enabled cycle
  always_comb begin
    id_next  = id_reg;
    rot_next = rotate_in;
    if (!reset_n_in) begin
      id_next = id_strap_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (clk_en_in || !reset_n_in) begin
      id_reg  <= id_next;
      rot_reg <= rot_next;
    end
  end

  assign bus.processor_id             = id_reg;
  assign bus.rotating_priority_select = rot_reg;
  assign bus.host_select_n            = ~host_select_in;
  assign bus.host_bus_request_n       = ~host_request_in;
  assign bus.dma_request_one_n        = ~dma_one_in;
  assign bus.dma_request_two_n        = ~dma_two_in;
  // All six lines driven from peer_request_in, own line included; the device masks its own line
  always_comb begin
    for (int i = 0; i < EBA_NUM_PROC; i++) begin
      bus.mp_bus_request_lines_n[i] = ~peer_request_in[i];
    end
  end
  assign host_granted_out    = ~bus.host_bus_grant_n;
  assign host_wait_out       = bus.host_ack_ready_oe & ~bus.host_ack_ready;
  assign dma_one_granted_out = bus.dma_grant_oe & ~bus.dma_grant_one_n;
  assign dma_two_granted_out = bus.dma_grant_oe & ~bus.dma_grant_two_n;
  assign device_master_out   = bus.bus_master_indicator;
endmodule

/* external_bus_arbitration_handshake_tb_top.sv */
// Bench joining both ends of the external bus arbiter
module external_bus_arbitration_handshake_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import eba_pkg::*;
  logic clk_in = 1'b0;
  logic rn = 1'b0, want = 1'b0, busy = 1'b0, rot = 1'b0;
  logic hs = 1'b0, hr = 1'b0, d1 = 1'b0, d2 = 1'b0;
  logic [2:0] id = 3'h1;
  logic [5:0] peer = 6'h00;
  logic [7:0] rnd = 8'h49;
  logic h_gnt, h_wait, g1, g2, mst, s1, s2;
  eba_state_t st;
  int errors = 0, compares = 0;
  int exp_q[$];
  eba_bus_if bus ();
  always #12.5 clk_in = ~clk_in;
  eba_device_end i_eba_device_end (.clk_in(clk_in), .reset_n_in(rn),
    .clk_en_in(1'b1), .want_bus_in(want), .io_processor_busy_in(busy),
    .dma_one_ready_in(1'b1), .dma_two_ready_in(1'b1),
    .dma_one_start_out(s1), .dma_two_start_out(s2), .state_out(st),
    .bus(bus));
  eba_system_end i_eba_system_end (.clk_in(clk_in), .reset_n_in(rn),
    .clk_en_in(1'b1), .id_strap_in(id), .rotate_in(rot),
    .host_select_in(hs), .host_request_in(hr), .dma_one_in(d1),
    .dma_two_in(d2), .peer_request_in(peer), .host_granted_out(h_gnt),
    .host_wait_out(h_wait), .dma_one_granted_out(g1),
    .dma_two_granted_out(g2), .device_master_out(mst), .bus(bus));
  eba_arb_properties i_chk (.clk_in(clk_in), .reset_n_in(rn),
    .processor_id(bus.processor_id), .host_select_n(bus.host_select_n),
    .rotating_priority_select(bus.rotating_priority_select),
    .host_bus_request_n(bus.host_bus_request_n),
    .host_ack_ready(bus.host_ack_ready),
    .host_ack_ready_oe(bus.host_ack_ready_oe),
    .host_bus_grant_n(bus.host_bus_grant_n),
    .dma_request_one_n(bus.dma_request_one_n),
    .dma_grant_one_n(bus.dma_grant_one_n),
    .dma_grant_two_n(bus.dma_grant_two_n), .dma_grant_oe(bus.dma_grant_oe),
    .mp_bus_request_lines_n(bus.mp_bus_request_lines_n),
    .mp_bus_request_oe(bus.mp_bus_request_oe),
    .bus_master_indicator(bus.bus_master_indicator));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic rst(input logic [2:0] v);
    rn = 1'b0;
    id = v;
    cyc(16);
    rn = 1'b1;
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(1);
    rst(3'h0);
    cyc(2);
    chk(mst, 1'b1);
    chk(bus.mp_bus_request_oe, 6'h00);
    want = 1'b1;
    rst(3'h1);
    for (int i = 0; i < 8 && mst !== 1'b1; i++) cyc(1);
    chk(bus.mp_bus_request_oe, 6'h01);
    d1 = 1'b1;
    d2 = 1'b1;
    for (int i = 0; i < 8 && g1 !== 1'b1; i++) cyc(1);
    chk({g1, g2}, 2'b10);
    cyc(1);
    chk(s1, 1'b1);
    d1 = 1'b0;
    for (int i = 0; i < 8 && g2 !== 1'b1; i++) cyc(1);
    chk(g2, 1'b1);
    cyc(1);
    chk(s2, 1'b1);
    d2 = 1'b0;
    hr = 1'b1;
    for (int i = 0; i < 8 && h_gnt !== 1'b1; i++) cyc(1);
    chk({h_gnt, mst}, 2'b10);
    chk(st, EBA_ST_HOST);
    cyc(5);
    chk(h_gnt, 1'b1);
    hr = 1'b0;
    for (int i = 0; i < 8 && mst !== 1'b1; i++) cyc(1);
    chk({h_gnt, mst}, 2'b01);
    exp_q.push_back(0);
    repeat (64) begin
      chk(h_wait, exp_q.pop_front());
      rnd = lfsr(rnd);
      {hs, hr, busy} = rnd[2:0];
      peer = {rnd[7:3], 1'b0};
      exp_q.push_back(hs & hr & busy);
      cyc(1);
    end
    {hs, hr, busy} = 3'h0;
    // Rotating priority: after release ID1 drops below ID2
    rot = 1'b1;
    peer = 6'h00;
    rst(3'h1);
    for (int i = 0; i < 8 && mst !== 1'b1; i++) cyc(1);
    chk(mst, 1'b1);
    want = 1'b0;
    peer = 6'h02;
    cyc(3);
    chk(mst, 1'b0);
    want = 1'b1;
    cyc(6);
    chk(mst, 1'b0);
    rot = 1'b0;
    for (int i = 0; i < 8 && mst !== 1'b1; i++) cyc(1);
    chk(mst, 1'b1);
    peer = 6'h01;
    rst(3'h2);
    cyc(6);
    chk(mst, 1'b0);
    peer = 6'h00;
    for (int i = 0; i < 8 && mst !== 1'b1; i++) cyc(1);
    chk(bus.mp_bus_request_oe, 6'h02);
    conclude;
  end
  initial begin
    #40000;
    errors++;
    conclude;
  end
endmodule
